/* common/fsps_consts.svh */
// flash self-program sequencer: register map, field positions, keys
// assumes byte-wide registers, one per aligned 32-bit apb word
// ------------------------------------------------------------
// ------------------------------------------------------------
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
`define FSPS_OFS_CMD 12'h000
`define FSPS_OFS_APH 12'h004
`define FSPS_OFS_APL 12'h008
`define FSPS_OFS_APHC 12'h00C
`define FSPS_OFS_APLC 12'h010
`define FSPS_OFS_WBUF 12'h014
`define FSPS_OFS_STAT 12'h018
`define FSPS_OFS_KEY 12'h01C
`define FSPS_OFS_MODE 12'h020
`define FSPS_OFS_WDOG 12'h024
`define FSPS_OFS_ISTS 12'h028
`define FSPS_OFS_IMSK 12'h02C
`define FSPS_STAT_SEQ 0
`define FSPS_STAT_VERIFY 1
`define FSPS_STAT_PROT 2
`define FSPS_IRQ_DONE 0
`define FSPS_IRQ_ERR 1
`define FSPS_IRQ_SEQ 2
`define FSPS_KEY_PROTECT 8'hA5
`define FSPS_KEY_WDT 8'hAC
`define FSPS_BLANK 8'hFF
`define FSPS_BYTE_FIRST 8'h00
`define FSPS_RST_BYTE 8'h00
`endif

/* common/fsps_pkg.sv */
// types shared by the sequencer, its flash engine and its mode guard
// assumes fsps_consts.svh for offsets, bit positions and keys; command codes and state encodings are defined here
package fsps_pkg;
   typedef enum logic [7:0] {FSPS_CMD_ERASE = 8'h03, FSPS_CMD_BLANK = 8'h04,
      FSPS_CMD_WRITE = 8'h05} fsps_cmd_t;
   typedef enum logic [1:0] {FSPS_FL_ERASE = 2'h0, FSPS_FL_PROG = 2'h1, FSPS_FL_READ = 2'h2} fsps_fkind_t;
   typedef enum logic [1:0] {FSPS_ST_IDLE = 2'b00, FSPS_ST_RUN = 2'b01, FSPS_ST_RESUME = 2'b11,
      FSPS_ST_HALT = 2'b10} fsps_state_t;
   typedef enum logic [1:0] {FSPS_EN_IDLE = 2'b00, FSPS_EN_OPER = 2'b01, FSPS_EN_READ = 2'b11,
      FSPS_EN_DONE = 2'b10} fsps_en_state_t;
   typedef enum logic [1:0] {FSPS_GD_IDLE = 2'b00, FSPS_GD_ARM = 2'b01, FSPS_GD_INV = 2'b11,
      FSPS_GD_SET = 2'b10} fsps_gd_state_t;
   typedef struct packed {
      fsps_state_t state;
      logic [7:0] cmd, aph, apl, aphc, aplc, wbuf;
      logic [2:0] stat, ists, imsk;
      logic [31:0] prdata;
      logic wdt;
   } fsps_top_st_t;
   typedef struct packed {
      fsps_en_state_t state;
      fsps_fkind_t kind;
      logic [7:0] block, addr, last, data;
      logic req, verr, done;
   } fsps_eng_st_t;
   typedef struct packed {
      fsps_gd_state_t state;
      logic [7:0] value;
      logic mode, err;
   } fsps_gd_st_t;
endpackage

/* rtl/fsps_guard.sv */
// protected mode-change sequence for self-programming mode
// assumes write pulses come from completed apb accesses
`timescale 1ns/10ps
`include "fsps_consts.svh"
module fsps_guard (
   // clock and reset
   input logic clk,
   input logic reset_n,
   // register writes
   input logic key_wr,
   input logic mode_wr,
   input logic [7:0] wdata,
   // result
   output logic self_mode,
   output logic seq_err
);
   import fsps_pkg::*;
   fsps_gd_st_t q, d;
   always_comb begin
      d = q;
      d.err = 1'b0;
      if (key_wr) begin
         d.state = (wdata == `FSPS_KEY_PROTECT) ? FSPS_GD_ARM : FSPS_GD_IDLE;
         d.err = (wdata != `FSPS_KEY_PROTECT);
      end else if (mode_wr) begin
         case (q.state)
            FSPS_GD_ARM: begin
               d.value = wdata;
               d.state = FSPS_GD_INV;
            end
            FSPS_GD_INV: begin
               d.state = (wdata == ~q.value) ? FSPS_GD_SET : FSPS_GD_IDLE;
               d.err = (wdata != ~q.value);
            end
            FSPS_GD_SET: begin
               // only the third write changes the mode
               if (wdata == q.value) d.mode = q.value[0];
               d.err = (wdata != q.value);
               d.state = FSPS_GD_IDLE;
            end
            default: d.err = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) q <= '0;
      else q <= d;
   end
   assign self_mode = q.mode;
   assign seq_err = q.err;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   unkeyed_write_a: assert property (mode_wr && !key_wr && q.state == FSPS_GD_IDLE
      |=> seq_err && $stable(self_mode)) else $error("unkeyed mode write not flagged");
   good_sequence_a: assert property (q.state == FSPS_GD_SET && mode_wr && !key_wr && wdata == q.value
      |=> self_mode == $past(q.value[0]) && !seq_err) else $error("mode not set by sequence");
endmodule // fsps_guard

/* rtl/fsps_engine.sv */
// flash operation engine: erase, program, read-back verify
// assumes flash macro acks each held request with a one-cycle pulse
`timescale 1ns/10ps
`include "fsps_consts.svh"
module fsps_engine (
   // clock and reset
   input logic clk,
   input logic reset_n,
   // command
   input logic start,
   input logic [7:0] op,
   input logic [7:0] block,
   input logic [7:0] first,
   input logic [7:0] last,
   input logic [7:0] wdata,
   output logic done,
   output logic verr,
   // flash macro
   output logic flash_req,
   output fsps_pkg::fsps_fkind_t flash_kind,
   output logic [7:0] flash_block,
   output logic [7:0] flash_addr,
   output logic [7:0] flash_wdata,
   input logic flash_ack,
   input logic [7:0] flash_rdata
);
   import fsps_pkg::*;
   fsps_eng_st_t q, d;
   always_comb begin
      d = q;
      d.done = 1'b0;
      case (q.state)
         FSPS_EN_IDLE: if (start) begin
            d.block = block;
            d.verr = 1'b0;
            d.req = 1'b1;
            d.data = (op == FSPS_CMD_WRITE) ? wdata : `FSPS_BLANK;
            if (op == FSPS_CMD_ERASE) begin
               // erase is followed by a blank verify of the whole block
               d.kind = FSPS_FL_ERASE;
               d.addr = `FSPS_BYTE_FIRST;
               d.last = `FSPS_BLANK;
               d.state = FSPS_EN_OPER;
            end else if (op == FSPS_CMD_WRITE) begin
               d.kind = FSPS_FL_PROG;
               d.addr = first;
               d.last = first;
               d.state = FSPS_EN_OPER;
            end else begin
               // first above last wraps through the block end
               d.kind = FSPS_FL_READ;
               d.addr = first;
               d.last = last;
               d.state = FSPS_EN_READ;
            end
         end
         FSPS_EN_OPER: if (flash_ack) begin
            d.kind = FSPS_FL_READ;
            d.state = FSPS_EN_READ;
         end
         FSPS_EN_READ: if (flash_ack) begin
            if (flash_rdata != q.data) d.verr = 1'b1;
            if (q.addr == q.last) begin
               d.req = 1'b0;
               d.done = 1'b1;
               d.state = FSPS_EN_DONE;
            end else d.addr = q.addr + 8'h01;
         end
         default: d.state = FSPS_EN_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) q <= '0;
      else q <= d;
   end
   assign done = q.done;
   assign verr = q.verr;
   assign flash_req = q.req;
   assign flash_kind = q.kind;
   assign flash_block = q.block;
   assign flash_addr = q.addr;
   assign flash_wdata = q.data;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   prog_data_a: assert property (q.state == FSPS_EN_IDLE && start && op == FSPS_CMD_WRITE
      |=> flash_req && flash_kind == FSPS_FL_PROG && flash_wdata == $past(wdata)) else $error("bad program");
   blank_read_a: assert property (q.state == FSPS_EN_IDLE && start && op == FSPS_CMD_BLANK
      |=> flash_kind == FSPS_FL_READ && flash_addr == $past(first)) else $error("bad blank check");
endmodule // fsps_engine

/* rtl/fsps_top.sv */
// flash self-program sequencer: apb registers, halt handshake, status
// assumes cpu_halt pulses once per HALT and the cpu stalls on cpu_hold
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "fsps_consts.svh"
module fsps_top (
   // clock and reset
   input logic clk,
   input logic reset_n,
   // apb slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu halt handshake
   input logic cpu_halt,
   input logic cpu_wake,
   output logic cpu_hold,
   output logic cpu_resume,
   // flash macro
   output logic flash_req,
   output fsps_pkg::fsps_fkind_t flash_kind,
   output logic [7:0] flash_block,
   output logic [7:0] flash_addr,
   output logic [7:0] flash_wdata,
   input logic flash_ack,
   input logic [7:0] flash_rdata,
   // protection boundary
   input logic [7:0] protect_below,
   // watchdog and interrupt
   output logic wdt_restart,
   output logic irq
);
   import fsps_pkg::*;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // one decode shared by write enable and error response; the read mux compares offsets on its own
   function automatic logic fsps_mapped(input logic [11:0] a);
      fsps_mapped = (a == `FSPS_OFS_CMD) ||
         (a == `FSPS_OFS_APH) ||
         (a == `FSPS_OFS_APL) ||
         (a == `FSPS_OFS_APHC) ||
         (a == `FSPS_OFS_APLC) ||
         (a == `FSPS_OFS_WBUF) ||
         (a == `FSPS_OFS_STAT) ||
         (a == `FSPS_OFS_KEY) ||
         (a == `FSPS_OFS_MODE) ||
         (a == `FSPS_OFS_WDOG) ||
         (a == `FSPS_OFS_ISTS) ||
         (a == `FSPS_OFS_IMSK);
   endfunction

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   fsps_top_st_t q, d;
   logic self_mode;
   logic seq_err;
   logic eng_done;
   logic eng_verr;
   logic eng_start;
   logic wr_acc;
   logic rd_setup;
   logic key_wr;
   logic mode_wr;
   logic cmd_ok;
   logic cmd_prot;
   logic [7:0] wd;

   assign wd = pwdata[7:0];
   // unmapped writes never reach a register or the mode guard
   assign wr_acc = psel && penable && pwrite && fsps_mapped(paddr);
   // read data latched at setup, so the access phase needs no wait state
   assign rd_setup = psel && !penable && !pwrite;
   assign key_wr = wr_acc && (paddr == `FSPS_OFS_KEY);
   assign mode_wr = wr_acc && (paddr == `FSPS_OFS_MODE);

   // ------------------------------------------------------------
   // command qualification
   // ------------------------------------------------------------
   // unknown codes fall back to an ordinary halt, never a flash access
   assign cmd_ok = (q.cmd == FSPS_CMD_ERASE) ||
      (q.cmd == FSPS_CMD_BLANK) ||
      (q.cmd == FSPS_CMD_WRITE);
   // blank check only reads, so protection does not apply to it
   assign cmd_prot = (q.cmd != FSPS_CMD_BLANK) && (q.aph < protect_below);
   assign eng_start = (q.state == FSPS_ST_IDLE) && cpu_halt && self_mode && cmd_ok && !cmd_prot;

   // ------------------------------------------------------------
   // sub-blocks
   // ------------------------------------------------------------
   fsps_guard u_guard (
      .clk(clk),
      .reset_n(reset_n),
      .key_wr(key_wr),
      .mode_wr(mode_wr),
      .wdata(wd),
      .self_mode(self_mode),
      .seq_err(seq_err)
   );

   // the high compare register is kept for software; a blank check walks low pointer to low compare
   fsps_engine u_engine (
      .clk(clk),
      .reset_n(reset_n),
      .start(eng_start),
      .op(q.cmd),
      .block(q.aph),
      .first(q.apl),
      .last(q.aplc),
      .wdata(q.wbuf),
      .done(eng_done),
      .verr(eng_verr),
      .flash_req(flash_req),
      .flash_kind(flash_kind),
      .flash_block(flash_block),
      .flash_addr(flash_addr),
      .flash_wdata(flash_wdata),
      .flash_ack(flash_ack),
      .flash_rdata(flash_rdata)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic ev_done;
      logic ev_err;
      ev_done = 1'b0;
      ev_err = 1'b0;
      d = q;
      d.wdt = 1'b0;
      // register writes, taken in the access phase
      if (wr_acc) begin
         if (paddr == `FSPS_OFS_CMD) begin
            d.cmd = wd;
         end else if (paddr == `FSPS_OFS_APH) begin
            d.aph = wd;
         end else if (paddr == `FSPS_OFS_APL) begin
            d.apl = wd;
         end else if (paddr == `FSPS_OFS_APHC) begin
            d.aphc = wd;
         end else if (paddr == `FSPS_OFS_APLC) begin
            d.aplc = wd;
         end else if (paddr == `FSPS_OFS_WBUF) begin
            d.wbuf = wd;
         end else if (paddr == `FSPS_OFS_STAT) begin
            // writing 00H clears; a written one never sets a flag
            d.stat = q.stat & wd[2:0];
         end else if (paddr == `FSPS_OFS_WDOG) begin
            d.wdt = (wd == `FSPS_KEY_WDT);
         end else if (paddr == `FSPS_OFS_ISTS) begin
            d.ists = q.ists & ~wd[2:0];
         end else if (paddr == `FSPS_OFS_IMSK) begin
            d.imsk = wd[2:0];
         end
      end
      // read data captured in the setup phase
      if (rd_setup) begin
         if (paddr == `FSPS_OFS_CMD) begin
            d.prdata = {24'h000000, q.cmd};
         end else if (paddr == `FSPS_OFS_APH) begin
            d.prdata = {24'h000000, q.aph};
         end else if (paddr == `FSPS_OFS_APL) begin
            d.prdata = {24'h000000, q.apl};
         end else if (paddr == `FSPS_OFS_APHC) begin
            d.prdata = {24'h000000, q.aphc};
         end else if (paddr == `FSPS_OFS_APLC) begin
            d.prdata = {24'h000000, q.aplc};
         end else if (paddr == `FSPS_OFS_WBUF) begin
            d.prdata = {24'h000000, q.wbuf};
         end else if (paddr == `FSPS_OFS_STAT) begin
            d.prdata = {29'h00000000, q.stat};
         end else if (paddr == `FSPS_OFS_MODE) begin
            d.prdata = {31'h00000000, self_mode};
         end else if (paddr == `FSPS_OFS_ISTS) begin
            d.prdata = {29'h00000000, q.ists};
         end else if (paddr == `FSPS_OFS_IMSK) begin
            d.prdata = {29'h00000000, q.imsk};
         end else begin
            d.prdata = 32'h00000000;
         end
      end
      // halt sequencing
      case (q.state)
         FSPS_ST_IDLE: if (cpu_halt) begin
            if (self_mode && cmd_ok) begin
               if (cmd_prot) begin
                  d.stat[`FSPS_STAT_PROT] = 1'b1;
                  ev_err = 1'b1;
                  ev_done = 1'b1;
                  d.state = FSPS_ST_RESUME;
               end else begin
                  d.state = FSPS_ST_RUN;
               end
            end else begin
               d.state = FSPS_ST_HALT;
            end
         end
         FSPS_ST_RUN: if (eng_done) begin
            // a clean run leaves the flags as software cleared them
            if (eng_verr) begin
               d.stat[`FSPS_STAT_VERIFY] = 1'b1;
               ev_err = 1'b1;
            end
            ev_done = 1'b1;
            d.state = FSPS_ST_RESUME;
         end
         FSPS_ST_HALT: if (cpu_wake) begin
            d.state = FSPS_ST_RESUME;
         end
         default: begin
            d.state = FSPS_ST_IDLE;
         end
      endcase
      // hardware sets win over a same-cycle software clear
      if (seq_err) begin
         d.stat[`FSPS_STAT_SEQ] = 1'b1;
         d.ists[`FSPS_IRQ_SEQ] = 1'b1;
      end
      if (ev_done) begin
         d.ists[`FSPS_IRQ_DONE] = 1'b1;
      end
      if (ev_err) begin
         d.ists[`FSPS_IRQ_ERR] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // every field resets to zero, state included
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = q.prdata;
   // zero wait states: the access phase always completes
   assign pready = 1'b1;
   assign pslverr = psel && penable && !fsps_mapped(paddr);
   // hold covers both a flash run and an ordinary halt
   assign cpu_hold = (q.state == FSPS_ST_RUN) || (q.state == FSPS_ST_HALT);
   assign cpu_resume = (q.state == FSPS_ST_RESUME);
   assign wdt_restart = q.wdt;
   // level output: stays up until software clears or masks the cause
   assign irq = |(q.ists & q.imsk);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   halt_start_a: assert property (q.state == FSPS_ST_IDLE && cpu_halt && self_mode && cmd_ok && !cmd_prot
      |=> q.state == FSPS_ST_RUN && cpu_hold && flash_req)
      else $error("prepared command did not start on halt");

   normal_halt_a: assert property (q.state == FSPS_ST_IDLE && cpu_halt && !self_mode
      |=> cpu_hold && !flash_req && q.state == FSPS_ST_HALT)
      else $error("halt in normal mode touched flash");

   resume_next_a: assert property (q.state == FSPS_ST_RUN && eng_done
      |=> cpu_resume ##1 !cpu_hold && !cpu_resume)
      else $error("no resume after command completion");

   protect_flag_a: assert property (q.state == FSPS_ST_IDLE && cpu_halt && self_mode && cmd_ok && cmd_prot
      |=> q.stat[`FSPS_STAT_PROT] && cpu_resume && !flash_req)
      else $error("protection error not reported");

   verify_flag_a: assert property (q.state == FSPS_ST_RUN && eng_done && eng_verr && !seq_err
      |=> q.stat[`FSPS_STAT_VERIFY])
      else $error("verify error not reported");

   clean_run_a: assert property (q.state == FSPS_ST_RUN && eng_done && !eng_verr && q.stat == 3'h0 && !seq_err
      |=> q.stat == 3'h0)
      else $error("clean run raised a flag");

   status_read_a: assert property (rd_setup && paddr == `FSPS_OFS_STAT
      |=> prdata == {29'h00000000, $past(q.stat)})
      else $error("status read mismatch");

   wdt_kick_a: assert property (wr_acc && paddr == `FSPS_OFS_WDOG && wd == `FSPS_KEY_WDT
      |=> wdt_restart ##1 !wdt_restart)
      else $error("watchdog key not forwarded");

   erase_kind_a: assert property (eng_start && q.cmd == FSPS_CMD_ERASE
      |=> flash_kind == FSPS_FL_ERASE && flash_block == $past(q.aph))
      else $error("erase not issued for code 03h");

   seq_flag_a: assert property (seq_err |=> q.stat[`FSPS_STAT_SEQ] && q.ists[`FSPS_IRQ_SEQ])
      else $error("sequence error not recorded");

   // halt and run sequencing
   wake_resume_a: assert property (q.state == FSPS_ST_HALT && cpu_wake
      |=> cpu_resume && !cpu_hold && !flash_req)
      else $error("ordinary halt did not resume on wake");

   bad_code_a: assert property (q.state == FSPS_ST_IDLE && cpu_halt && self_mode && !cmd_ok
      |=> q.state == FSPS_ST_HALT && !flash_req)
      else $error("unknown code touched flash");

   busy_halt_a: assert property (q.state == FSPS_ST_RUN && !eng_done
      |=> q.state == FSPS_ST_RUN && cpu_hold)
      else $error("command run left early");

   // pointer and data routing
   write_data_a: assert property (eng_start && q.cmd == FSPS_CMD_WRITE
      |=> flash_wdata == $past(q.wbuf) && flash_addr == $past(q.apl) && flash_block == $past(q.aph))
      else $error("byte write not aimed at pointers");

   blank_start_a: assert property (eng_start && q.cmd == FSPS_CMD_BLANK
      |=> flash_kind == FSPS_FL_READ && flash_block == $past(q.aph))
      else $error("blank check did not read block");

   blank_unprot_a: assert property (q.state == FSPS_ST_IDLE && cpu_halt && self_mode && q.cmd == FSPS_CMD_BLANK
      |=> q.state == FSPS_ST_RUN && flash_req)
      else $error("blank check refused");

   // status and interrupt
   status_clear_a: assert property (wr_acc && paddr == `FSPS_OFS_STAT && wd == 8'h00 && !seq_err && !cpu_halt
      && !eng_done |=> q.stat == 3'h0)
      else $error("status write did not clear");

   done_irq_a: assert property (q.state == FSPS_ST_RUN && eng_done
      |=> q.ists[`FSPS_IRQ_DONE])
      else $error("completion not recorded");

   erase_run_c: cover property (eng_start && q.cmd == FSPS_CMD_ERASE ##[1:20] flash_kind == FSPS_FL_READ);
   verify_fail_c: cover property (q.state == FSPS_ST_RUN && eng_done && eng_verr);
   protect_hit_c: cover property (q.state == FSPS_ST_IDLE && cpu_halt && self_mode && cmd_prot);
   normal_halt_c: cover property (q.state == FSPS_ST_HALT && cpu_wake);
   write_run_c: cover property (eng_start && q.cmd == FSPS_CMD_WRITE ##[1:40] cpu_resume);

endmodule // fsps_top

/* sim/test_flash_self_program_sequencer.sv */
// self-checking bench for the flash self-program sequencer
// assumes the bench itself plays apb master, cpu and flash macro
`timescale 1ns/10ps
`include "fsps_consts.svh"
module test_flash_self_program_sequencer;
   import fsps_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cpu_hold, cpu_resume, flash_req, wdt_restart, irq;
   logic cpu_halt = 1'b0, cpu_wake = 1'b0, flash_ack = 1'b0;
   fsps_fkind_t flash_kind;
   logic [7:0] flash_block, flash_addr, flash_wdata, flash_rdata = 8'h00, last_block = 8'h00;
   logic [7:0] protect_below = 8'h02;
   logic [7:0] mem [256];
   logic [1:0] fl_wait = 2'h0;
   int n_mismatch = 0, check_count = 0, cyc = 0, wdt_n = 0;
   fsps_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_halt(cpu_halt), .cpu_wake(cpu_wake), .cpu_hold(cpu_hold), .cpu_resume(cpu_resume),
      .flash_req(flash_req), .flash_kind(flash_kind), .flash_block(flash_block), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
      .protect_below(protect_below), .wdt_restart(wdt_restart), .irq(irq));
   always #2.5 clk = ~clk;
   // ------------------------------------------------------------
   // flash macro stand-in: ack after three cycles, data scrambled off ack
   // ------------------------------------------------------------
   always @(posedge clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (wdt_restart === 1'b1) wdt_n <= wdt_n + 1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         test_done();
      end
      if (flash_req === 1'b1 && !flash_ack) begin
         fl_wait <= fl_wait + 2'h1;
         if (fl_wait == 2'h2) begin
            fl_wait <= 2'h0;
            flash_ack <= 1'b1;
            last_block <= flash_block;
            flash_rdata <= mem[flash_addr];
            if (flash_kind == FSPS_FL_ERASE) for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
            if (flash_kind == FSPS_FL_PROG) mem[flash_addr] <= flash_wdata;
         end
      end
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [32:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r[31:0], exp[31:0]);
      chk({31'h0, r[32]}, {31'h0, exp[32]});
   endtask
   // wake: ordinary halt expected, ended by the cpu side
   task automatic halt_run(input logic wake);
      int k;
      @(posedge clk) cpu_halt <= 1'b1;
      @(posedge clk) cpu_halt <= 1'b0;
      if (wake) begin
         repeat (3) @(posedge clk);
         chk({30'h0, cpu_hold, flash_req}, 32'h2);
         cpu_wake <= 1'b1;
         @(posedge clk) cpu_wake <= 1'b0;
      end
      k = 0;
      while (cpu_resume !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, cpu_resume}, 32'h1);
   endtask
   task automatic mode(input logic [7:0] v, input logic [7:0] third);
      wr(`FSPS_OFS_KEY, `FSPS_KEY_PROTECT);
      wr(`FSPS_OFS_MODE, v);
      wr(`FSPS_OFS_MODE, ~v);
      wr(`FSPS_OFS_MODE, third);
      repeat (3) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic cmd(input logic [7:0] c, b, lo, lc, wb, input logic [31:0] st);
      wr(`FSPS_OFS_CMD, c);
      wr(`FSPS_OFS_APH, b);
      wr(`FSPS_OFS_APL, lo);
      wr(`FSPS_OFS_APHC, b);
      wr(`FSPS_OFS_APLC, lc);
      wr(`FSPS_OFS_WBUF, wb);
      wr(`FSPS_OFS_STAT, 8'h00);
      wr(`FSPS_OFS_WDOG, `FSPS_KEY_WDT);
      halt_run(1'b0);
      rd(`FSPS_OFS_STAT, {1'b0, st});
   endtask
   task automatic t_mode;
      mode(8'h01, 8'h00);
      rd(`FSPS_OFS_MODE, 33'h0);
      rd(`FSPS_OFS_STAT, 33'h1);
      rd(`FSPS_OFS_ISTS, 33'h4);
      chk({31'h0, irq}, 32'h1);
      wr(`FSPS_OFS_IMSK, 8'h00);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(`FSPS_OFS_IMSK, 8'h07);
      wr(`FSPS_OFS_ISTS, 8'h04);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      mode(8'h01, 8'h01);
      rd(`FSPS_OFS_MODE, 33'h1);
   endtask
   task automatic t_cmds;
      cmd(8'h03, 8'h07, 8'h00, 8'h00, 8'h00, 32'h0);
      chk({24'h0, last_block}, 32'h7);
      rd(`FSPS_OFS_ISTS, 33'h1);
      wr(`FSPS_OFS_ISTS, 8'h07);
      cmd(8'h04, 8'h07, 8'h00, 8'hFF, 8'h00, 32'h0);
      cmd(8'h05, 8'h07, 8'h20, 8'h00, 8'h10, 32'h0);
      chk({24'h0, mem[8'h20]}, 32'h10);
      cmd(8'h04, 8'h07, 8'h00, 8'hFF, 8'h00, 32'h2);
      cmd(8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 32'h4);
      cmd(8'h03, 8'h07, 8'h00, 8'h00, 8'h00, 32'h0);
      chk({24'h0, mem[8'h20]}, 32'hFF);
      wr(`FSPS_OFS_CMD, 8'h01);
      halt_run(1'b1);
   endtask
   task automatic t_misc;
      int n0;
      n0 = wdt_n;
      wr(`FSPS_OFS_WDOG, `FSPS_KEY_WDT);
      wr(`FSPS_OFS_WDOG, 8'hAB);
      repeat (2) @(posedge clk);
      chk(wdt_n - n0, 32'h1);
      rd(12'h100, 33'h1_0000_0000);
      mode(8'h00, 8'h00);
      rd(`FSPS_OFS_MODE, 33'h0);
      wr(`FSPS_OFS_CMD, 8'h03);
      halt_run(1'b1);
   endtask
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rd(`FSPS_OFS_STAT, 33'h0);
      wr(`FSPS_OFS_IMSK, 8'h07);
      wr(`FSPS_OFS_CMD, 8'h03);
      halt_run(1'b1);
      t_mode();
      t_cmds();
      t_misc();
      test_done();
   end
endmodule // test_flash_self_program_sequencer
